//--- design/tsec_event_ctrl.sv
`include "tsec_defs.svh"
`default_nettype none

module tsec_event_ctrl (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // Register port, all accesses need supervisor mode
  input wire tsec_pkg::tsec_reg_req_t reg_req_i,
  input wire logic supervisor_i,
  output tsec_pkg::tsec_reg_rsp_t reg_rsp_o,
  // Peripheral requests, level high while asserting
  input wire logic [55:0] periph_req_i,
  output logic [55:0] periph_ack_o,
  // Dedicated core events on levels 0 to 6 and software levels
  input wire logic [15:0] core_event_i,
  // Pipeline side
  input wire logic pipe_ready_i,
  input wire logic event_return_i,
  input wire logic global_enable_instruction_i,
  input wire logic global_disable_instruction_i,
  output tsec_pkg::tsec_dispatch_t dispatch_o,
  output logic [15:0] core_event_pending_o,
  // Power management
  input wire logic core_idle_i,
  output logic wakeup_o
);

  import tsec_pkg::*;

  //////////////////////////////////////////////////////////////////////////////

  tsec_state_t st_r;
  tsec_state_t st_nxt;
  logic [223:0] map;
  logic [31:0] mem_rdata;
  logic asgn_wr;
  logic asgn_rd;
  logic [2:0] asgn_idx;
  logic acc_ok;

  // Lowest set index, 16 when none; serves both priority searches
  function automatic logic [4:0] first_set(input logic [15:0] v);
    logic [4:0] r;
    r = 5'h10;
    for (int i = 15; i >= 0; i--) begin
      if (v[i]) begin
        r = 5'(i);
      end
    end
    return r;
  endfunction

  // Core id of one peripheral, taken from its assignment nibble
  function automatic logic [2:0] core_id(input logic [223:0] m, input int k);
    logic [3:0] nib;
    nib = m[k*`TSEC_ASGN_BITS +: `TSEC_ASGN_BITS];
    return nib[2:0];
  endfunction

  // Wired OR of all unmasked requests per core id
  function automatic logic [6:0] route(input logic [55:0] req, input logic [223:0] m);
    logic [6:0] lines;
    lines = 7'h00;
    for (int k = 0; k < 56; k++) begin
      for (int n = 0; n < 7; n++) begin
        if (req[k] && core_id(m, k) == 3'(n)) begin
          lines[n] = 1'b1; // R19 R23
        end
      end
    end
    return lines;
  endfunction

  //////////////////////////////////////////////////////////////////////////////

  assign acc_ok = supervisor_i; // R8 R10
  assign asgn_wr = reg_req_i.wr && acc_ok && reg_req_i.idx >= `TSEC_IDX_ASGN0;
  assign asgn_rd = reg_req_i.rd && acc_ok && reg_req_i.idx >= `TSEC_IDX_ASGN0;
  assign asgn_idx = 3'(reg_req_i.idx - `TSEC_IDX_ASGN0);

  tsec_asgn_mem u_asgn (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .wr_i(asgn_wr),
    .widx_i(asgn_idx),
    .wdata_i(reg_req_i.wdata),
    .rd_i(asgn_rd),
    .ridx_i(asgn_idx),
    .rdata_o(mem_rdata),
    .map_o(map)
  );

  //////////////////////////////////////////////////////////////////////////////

  always_comb begin
    logic [6:0] lines;
    logic [15:0] lvl_in;
    logic [15:0] rise;
    logic [15:0] gate;
    logic [15:0] cand;
    logic [15:0] pend_rise;
    logic [4:0] cur;
    logic [4:0] best;
    logic [31:0] rd_val;
    lines = 7'h00;
    lvl_in = 16'h0000;
    rise = 16'h0000;
    gate = 16'h0000;
    cand = 16'h0000;
    pend_rise = 16'h0000;
    cur = 5'h10;
    best = 5'h10;
    rd_val = 32'h0000_0000;
    st_nxt = st_r;

    // System stage routing onto general levels 7 to 13
    lines = route(periph_req_i & st_r.smask, map); // R12
    lvl_in = core_event_i | {2'b00, lines, 7'h00}; // R23

    // Edge detection: sample, then compare with the previous sample
    st_nxt.lvl_s1 = lvl_in;
    st_nxt.lvl_s2 = st_r.lvl_s1;
    rise = st_r.lvl_s1 & ~st_r.lvl_s2; // R15

    // Global gate covers levels 7 to 15 only; dedicated levels 0 to 6 always pass
    if (global_disable_instruction_i) begin
      st_nxt.gie = 1'b0; // R9
    end else if (global_enable_instruction_i) begin
      st_nxt.gie = 1'b1; // R9
    end
    gate = {{9{st_r.gie}}, 7'h7f}; // R9

    // Return from the innermost event clears its pending bit
    cur = first_set(st_r.pend);
    if (event_return_i && cur != 5'h10) begin
      st_nxt.pend[cur[3:0]] = 1'b0; // R10
    end

    // Software latch write: only bits whose mask is clear
    if (reg_req_i.wr && acc_ok && reg_req_i.idx == `TSEC_IDX_LATCH) begin
      st_nxt.latch = (st_r.latch & st_r.mask) | (reg_req_i.wdata[15:0] & ~st_r.mask); // R6
    end

    // Dispatch only if strictly more urgent than the active level
    cand = st_r.latch & st_r.mask & gate; // R7
    best = first_set(cand);
    st_nxt.take = 1'b0;
    if (pipe_ready_i && best < cur) begin // R22
      st_nxt.pend[best[3:0]] = 1'b1; // R10 R17
      st_nxt.latch[best[3:0]] = 1'b0; // R6 R16
      st_nxt.take = 1'b1;
      st_nxt.take_lvl = best[3:0];
    end

    // A new edge in the clearing cycle is still queued
    st_nxt.latch = st_nxt.latch | rise; // R15 R16

    // Pending rise acknowledges the peripherals behind that level
    pend_rise = st_nxt.pend & ~st_r.pend;
    for (int k = 0; k < 56; k++) begin
      st_nxt.ack[k] = periph_req_i[k] && st_r.smask[k] &&
                      pend_rise[`TSEC_GP_BASE + 4'(core_id(map, k))] &&
                      core_id(map, k) != `TSEC_NUM_CORE_ID; // R18
    end

    // Wakeup from idle or sleep
    st_nxt.wake = core_idle_i && |(periph_req_i & st_r.wake_en); // R14

    // Register writes
    if (reg_req_i.wr && acc_ok) begin
      unique case (reg_req_i.idx)
        `TSEC_IDX_MASK: st_nxt.mask = reg_req_i.wdata[15:0]; // R5 R8
        `TSEC_IDX_SMASK_LO: st_nxt.smask[31:0] = reg_req_i.wdata; // R11
        `TSEC_IDX_SMASK_HI: st_nxt.smask[55:32] = reg_req_i.wdata[23:0]; // R11
        `TSEC_IDX_WAKE_LO: st_nxt.wake_en[31:0] = reg_req_i.wdata; // R11
        `TSEC_IDX_WAKE_HI: st_nxt.wake_en[55:32] = reg_req_i.wdata[23:0]; // R11
        default: begin
        end
      endcase
    end

    // Reads: capture now, present two cycles later
    if (reg_req_i.rd && acc_ok) begin
      unique case (reg_req_i.idx)
        `TSEC_IDX_LATCH: rd_val = {16'h0000, st_r.latch};
        `TSEC_IDX_MASK: rd_val = {16'h0000, st_r.mask}; // R8
        `TSEC_IDX_PEND: rd_val = {16'h0000, st_r.pend}; // R10
        `TSEC_IDX_SMASK_LO: rd_val = st_r.smask[31:0];
        `TSEC_IDX_SMASK_HI: rd_val = {8'h00, st_r.smask[55:32]};
        `TSEC_IDX_STAT_LO: rd_val = periph_req_i[31:0]; // R13
        `TSEC_IDX_STAT_HI: rd_val = {8'h00, periph_req_i[55:32]}; // R13
        `TSEC_IDX_WAKE_LO: rd_val = st_r.wake_en[31:0];
        `TSEC_IDX_WAKE_HI: rd_val = {8'h00, st_r.wake_en[55:32]};
        default: rd_val = 32'h0000_0000;
      endcase
    end
    st_nxt.rd_p1 = reg_req_i.rd;
    st_nxt.rd_asgn = asgn_rd;
    st_nxt.rd_hold = rd_val;
    st_nxt.rvalid = st_r.rd_p1;
    if (st_r.rd_p1) begin
      st_nxt.rdata = st_r.rd_asgn ? mem_rdata : st_r.rd_hold;
    end
  end

  //////////////////////////////////////////////////////////////////////////////

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r <= '0;
      st_r.latch <= `TSEC_RST_LATCH;
      st_r.mask <= `TSEC_RST_MASK;
      st_r.pend <= `TSEC_RST_PEND;
      st_r.gie <= `TSEC_RST_GIE;
      st_r.smask <= `TSEC_RST_SMASK;
      st_r.wake_en <= `TSEC_RST_WAKE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Every output straight from the state register
  assign reg_rsp_o.valid = st_r.rvalid;
  assign reg_rsp_o.data = st_r.rdata;
  assign periph_ack_o = st_r.ack;
  assign dispatch_o.take = st_r.take;
  assign dispatch_o.level = st_r.take_lvl;
  assign core_event_pending_o = st_r.pend;
  assign wakeup_o = st_r.wake;

endmodule

`default_nettype wire

//--- design/tsec_defs.svh
// How it works
// (R1) Reset map: peripheral events 14 and 15 go to core id 1.
// (R2) Reset map: peripheral events 16 to 19 go to core id 2.
// (R3) Reset map: events 20 to 25 and 51 to 55 go to core id 3.
// (R4) Reset map: 26-31 to 4, 32-41 to 5, 42-46 to 6, 47-50 to 0.
// (R5) Core latch, mask and pending registers are 16 bits, one per level.
// (R6) Latch sets on capture, clears on accept; software writes only unmasked-clear bits.
// (R7) Set mask bit lets a level be serviced; clear bit blocks it, latch kept.
// (R8) Core mask readable and writable only in supervisor mode.
// (R9) Global enable and disable instructions gate all general-purpose levels.
// (R10) Pending is hardware-only, tracks nesting, readable in supervisor mode.
// (R11) System stage has mask, status and wakeup-enable pairs of 32-bit registers.
// (R12) System mask bit set passes a peripheral event; clear blocks it.
// (R13) System status bit reads one while its peripheral asserts its request.
// (R14) Wakeup-enabled event wakes the processor while the core is idle or asleep.
// (R15) Latch sets on a rising edge of the level input, two cycles detection.
// (R16) Latch clears when pending sets; the next rising edge is then queued.
// (R17) Rising edge to pending output takes at least three cycles.
// (R18) System stage treats a set pending bit as the peripheral acknowledgement.
// (R19) Shared inputs tolerate simultaneous and overlapping peripheral assertions.
// (R20) Software rewrites the peripheral assignment registers to remap priorities.
// (R21) Reset map: peripheral events 0 to 13 go to core id 0.
// (R22) Level 0 is highest priority; higher levels preempt and nest.
// (R23) Core id n drives level 7 plus n, the OR of unmasked assigned requests.
`ifndef TSEC_DEFS_SVH
`define TSEC_DEFS_SVH

// Register indices on the register port
`define TSEC_IDX_LATCH 4'h0
`define TSEC_IDX_MASK 4'h1
`define TSEC_IDX_PEND 4'h2
`define TSEC_IDX_SMASK_LO 4'h3
`define TSEC_IDX_SMASK_HI 4'h4
`define TSEC_IDX_STAT_LO 4'h5
`define TSEC_IDX_STAT_HI 4'h6
`define TSEC_IDX_WAKE_LO 4'h7
`define TSEC_IDX_WAKE_HI 4'h8
`define TSEC_IDX_ASGN0 4'h9
`define TSEC_IDX_ASGN6 4'hf

// Field layout
`define TSEC_GP_BASE 4'h7
`define TSEC_ASGN_BITS 4
`define TSEC_NUM_CORE_ID 3'h7

// Reset values
`define TSEC_RST_LATCH 16'h0000
`define TSEC_RST_MASK 16'h0000
`define TSEC_RST_PEND 16'h0000
`define TSEC_RST_SMASK 56'h00_0000_0000_0000
`define TSEC_RST_WAKE 56'h00_0000_0000_0000
`define TSEC_RST_GIE 1'h0
`define TSEC_RST_ASGN0 32'h0000_0000
`define TSEC_RST_ASGN1 32'h1100_0000
`define TSEC_RST_ASGN2 32'h3333_2222
`define TSEC_RST_ASGN3 32'h4444_4433
`define TSEC_RST_ASGN4 32'h5555_5555
`define TSEC_RST_ASGN5 32'h0666_6655
`define TSEC_RST_ASGN6 32'h3333_3000

`endif

//--- design/tsec_pkg.sv
`default_nettype none

package tsec_pkg;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] idx;
    logic [31:0] wdata;
  } tsec_reg_req_t;

  typedef struct packed {
    logic valid;
    logic [31:0] data;
  } tsec_reg_rsp_t;

  typedef struct packed {
    logic take;
    logic [3:0] level;
  } tsec_dispatch_t;

  typedef struct packed {
    logic [15:0] lvl_s1;
    logic [15:0] lvl_s2;
    logic [15:0] latch;
    logic [15:0] mask;
    logic [15:0] pend;
    logic gie;
    logic [55:0] smask;
    logic [55:0] wake_en;
    logic [55:0] ack;
    logic rd_p1;
    logic rd_asgn;
    logic [31:0] rd_hold;
    logic [31:0] rdata;
    logic rvalid;
    logic wake;
    logic take;
    logic [3:0] take_lvl;
  } tsec_state_t;

endpackage

`default_nettype wire

//--- design/tsec_asgn_mem.sv
`include "tsec_defs.svh"
`default_nettype none

module tsec_asgn_mem (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // Write port
  input wire logic wr_i,
  input wire logic [2:0] widx_i,
  input wire logic [31:0] wdata_i,
  // Read port
  input wire logic rd_i,
  input wire logic [2:0] ridx_i,
  output logic [31:0] rdata_o,
  // Whole map for the router
  output logic [223:0] map_o
);

  logic [6:0][31:0] mem_r;

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mem_r <= {`TSEC_RST_ASGN6, `TSEC_RST_ASGN5, `TSEC_RST_ASGN4, `TSEC_RST_ASGN3,
                `TSEC_RST_ASGN2, `TSEC_RST_ASGN1, `TSEC_RST_ASGN0}; // R1 R2 R3 R4 R21
      rdata_o <= 32'h0000_0000;
    end else begin
      if (wr_i && widx_i < 3'h7) begin
        mem_r[widx_i] <= wdata_i; // R20
      end
      if (rd_i) begin
        rdata_o <= (ridx_i < 3'h7) ? mem_r[ridx_i] : 32'h0000_0000;
      end
    end
  end

  assign map_o = mem_r;

endmodule

`default_nettype wire

//--- test/tsec_event_ctrl_props.sv
`default_nettype none

module tsec_event_ctrl_props (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // Register port
  input wire tsec_pkg::tsec_reg_req_t reg_req_i,
  input wire logic supervisor_i,
  input wire tsec_pkg::tsec_reg_rsp_t reg_rsp_o,
  // Events
  input wire logic [55:0] periph_req_i,
  input wire logic [55:0] periph_ack_o,
  input wire logic pipe_ready_i,
  input wire logic event_return_i,
  input wire logic global_disable_instruction_i,
  input wire tsec_pkg::tsec_dispatch_t dispatch_o,
  input wire logic [15:0] core_event_pending_o,
  input wire logic core_idle_i,
  input wire logic wakeup_o
);
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_n_i);

  sequence s_read;
    reg_req_i.rd && supervisor_i;
  endsequence
  sequence s_answer;
    ##2 reg_rsp_o.valid;
  endsequence
  sequence s_fresh_edge;
    $rose(periph_req_i[0]) && !core_event_pending_o[7];
  endsequence

  chk_read_answer: assert property (s_read |-> s_answer)
    else $error("read answer missing");
  chk_min_latency: assert property (s_fresh_edge |=> !core_event_pending_o[7])
    else $error("pending set too early");
  chk_ack_pending: assert property (|periph_ack_o |-> core_event_pending_o[13:7] != 7'h00)
    else $error("ack without pending level");
  chk_wake_idle: assert property (!core_idle_i || periph_req_i == 56'h0 |=> !wakeup_o)
    else $error("wakeup without cause");
  chk_take_ready: assert property (dispatch_o.take |-> $past(pipe_ready_i))
    else $error("take while pipeline not ready");
  chk_take_prio: assert property (dispatch_o.take |->
      ($past(core_event_pending_o) << (4'hf - dispatch_o.level)) == 16'h0000)
    else $error("take does not preempt");
  chk_gie_off: assert property (global_disable_instruction_i |->
      ##2 !(dispatch_o.take && dispatch_o.level >= 4'h7))
    else $error("general level taken while disabled");
  chk_pend_cause: assert property (core_event_pending_o != $past(core_event_pending_o) |->
      dispatch_o.take || $past(event_return_i))
    else $error("pending changed without cause");
endmodule

bind tsec_event_ctrl tsec_event_ctrl_props chk_u (.*);

`default_nettype wire

//--- test/tsec_pipe_model.sv
`default_nettype none

module tsec_pipe_model (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // Bench control and controller output
  input wire logic stall_i,
  input wire tsec_pkg::tsec_dispatch_t dispatch_i,
  // Toward the controller
  output logic pipe_ready_o,
  output logic event_return_o
);
  logic [3:0] busy_r;
  logic [1:0] depth_r;

  assign pipe_ready_o = !stall_i;

  // Each take opens a routine; a return resumes the outer one, so every take gets its return while nesting stays within three
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy_r <= 4'h0;
      depth_r <= 2'h0;
      event_return_o <= 1'b0;
    end else begin
      event_return_o <= busy_r == 4'h1;
      depth_r <= depth_r + {1'b0, dispatch_i.take} - {1'b0, busy_r == 4'h1};
      if (dispatch_i.take) begin
        busy_r <= stall_i ? 4'hc : 4'h4;
      end else if (busy_r == 4'h1) begin
        busy_r <= (depth_r > 2'h1) ? 4'h4 : 4'h0;
      end else if (busy_r != 4'h0) begin
        busy_r <= busy_r - 4'h1;
      end
    end
  end
endmodule

`default_nettype wire

//--- test/tsec_event_ctrl_test.sv
`include "tsec_defs.svh"
`default_nettype none

module tsec_event_ctrl_test;
  timeunit 1ns;
  timeprecision 1ps;
  import tsec_pkg::*;

  logic clock_i, rst_n_i, sup, gen, gdis, idle, wake, ready, ret, stall;
  tsec_reg_req_t req;
  tsec_reg_rsp_t rsp;
  tsec_dispatch_t disp;
  logic [55:0] preq, pack;
  logic [15:0] pend;
  int n_errors, n_checks;

  tsec_event_ctrl dut_u (.clock_i(clock_i), .rst_n_i(rst_n_i), .reg_req_i(req), .supervisor_i(sup),
    .reg_rsp_o(rsp), .periph_req_i(preq), .periph_ack_o(pack), .core_event_i(16'h0000),
    .pipe_ready_i(ready), .event_return_i(ret), .global_enable_instruction_i(gen),
    .global_disable_instruction_i(gdis), .dispatch_o(disp), .core_event_pending_o(pend),
    .core_idle_i(idle), .wakeup_o(wake));
  tsec_pipe_model pm_u (.clock_i(clock_i), .rst_n_i(rst_n_i), .stall_i(stall), .dispatch_i(disp),
    .pipe_ready_o(ready), .event_return_o(ret));

  initial begin
    clock_i = 1'b0;
    forever #2.5 clock_i = ~clock_i;
  end

  ////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic wr(input logic [3:0] i, input logic [31:0] d);
    @(negedge clock_i);
    req <= '{1'b1, 1'b0, i, d};
    @(negedge clock_i);
    req <= '0;
  endtask

  task automatic rdc(input logic [3:0] i, input logic [31:0] exp);
    @(negedge clock_i);
    req <= '{1'b0, 1'b1, i, 32'h0};
    @(negedge clock_i);
    req <= '0;
    // Answer stands for one cycle only, right after the second edge
    @(negedge clock_i);
    check({31'h0, rsp.valid}, 32'h1);
    check(rsp.data, exp);
  endtask

  task automatic gie(input logic on);
    @(negedge clock_i);
    gen <= on;
    gdis <= !on;
    @(negedge clock_i);
    gen <= 1'b0;
    gdis <= 1'b0;
  endtask

  // Level change must already be driven in this time step
  task automatic wait_take(input logic [3:0] lvl, input int least);
    int k;
    k = 0;
    while (disp.take !== 1'b1) begin
      @(negedge clock_i);
      k++;
      if (k > 40) begin
        n_errors++;
        summarize();
      end
    end
    check({28'h0, disp.level}, {28'h0, lvl});
    check({31'h0, k >= least}, 32'h1);
  endtask

  ////////////////////////////////////////////////////////////////
  task automatic t_access();
    rdc(`TSEC_IDX_MASK, 32'h0);
    wr(`TSEC_IDX_MASK, 32'h3f80);
    sup <= 1'b0;
    wr(`TSEC_IDX_MASK, 32'h0);
    rdc(`TSEC_IDX_MASK, 32'h0);
    sup <= 1'b1;
    rdc(`TSEC_IDX_MASK, 32'h3f80);
    wr(`TSEC_IDX_LATCH, 32'h4080);
    rdc(`TSEC_IDX_LATCH, 32'h4000);
    wr(`TSEC_IDX_LATCH, 32'h0);
    wr(`TSEC_IDX_PEND, 32'hffff);
    rdc(`TSEC_IDX_PEND, 32'h0);
  endtask

  task automatic t_route();
    logic [5:0] ids[12] = '{0, 13, 14, 15, 16, 19, 20, 26, 32, 42, 47, 55};
    logic [3:0] lv[12] = '{7, 7, 8, 8, 9, 9, 10, 11, 12, 13, 7, 10};
    gie(1'b1);
    wr(`TSEC_IDX_SMASK_LO, 32'hffff_ffff);
    wr(`TSEC_IDX_SMASK_HI, 32'h00ff_ffff);
    for (int i = 0; i < 12; i++) begin
      preq[ids[i]] <= 1'b1;
      wait_take(lv[i], 3);
      check({31'h0, pack[ids[i]]}, 32'h1);
      preq[ids[i]] <= 1'b0;
      repeat (8) @(negedge clock_i);
    end
    wr(`TSEC_IDX_ASGN0 + 4'h1, 32'h1600_0000);
    preq[14] <= 1'b1;
    wait_take(4'hd, 3);
    preq[14] <= 1'b0;
    repeat (8) @(negedge clock_i);
  endtask

  task automatic t_gate();
    wr(`TSEC_IDX_SMASK_LO, 32'hffff_bfff);
    preq[14] <= 1'b1;
    rdc(`TSEC_IDX_STAT_LO, 32'h0000_4000);
    repeat (2) @(negedge clock_i);
    check({16'h0, pend}, 32'h0);
    preq[14] <= 1'b0;
    gie(1'b0);
    preq[0] <= 1'b1;
    repeat (8) @(negedge clock_i);
    check({16'h0, pend}, 32'h0);
    rdc(`TSEC_IDX_LATCH, 32'h0080);
    gie(1'b1);
    wait_take(4'h7, 0);
    preq[0] <= 1'b0;
    repeat (8) @(negedge clock_i);
  endtask

  // Ready held low keeps the event latched, not lost
  task automatic t_wake();
    wr(`TSEC_IDX_WAKE_LO, 32'h0000_0002);
    stall <= 1'b1;
    idle <= 1'b1;
    preq[0] <= 1'b1;
    repeat (3) @(negedge clock_i);
    check({31'h0, wake}, 32'h0);
    preq[1] <= 1'b1;
    repeat (2) @(negedge clock_i);
    check({31'h0, wake}, 32'h1);
    check({16'h0, pend}, 32'h0);
    idle <= 1'b0;
    stall <= 1'b0;
    wait_take(4'h7, 0);
    repeat (2) @(negedge clock_i);
    check({31'h0, wake}, 32'h0);
  endtask

  // Level 7 preempts an active level 12; level 13 waits for both returns
  task automatic t_nest();
    preq[1:0] <= 2'b00;
    repeat (8) @(negedge clock_i);
    preq[32] <= 1'b1;
    wait_take(4'hc, 3);
    preq[0] <= 1'b1;
    preq[42] <= 1'b1;
    @(negedge clock_i);
    wait_take(4'h7, 2);
    check({16'h0, pend}, 32'h1080);
    @(negedge clock_i);
    wait_take(4'hd, 0);
    check({16'h0, pend}, 32'h2000);
  endtask

  initial begin
    rst_n_i = 1'b0;
    sup = 1'b1;
    {gen, gdis, idle, stall} = 4'h0;
    req = '0;
    preq = '0;
    n_errors = 0;
    n_checks = 0;
    repeat (10) @(negedge clock_i);
    rst_n_i = 1'b1;
    t_access();
    t_route();
    t_gate();
    t_wake();
    t_nest();
    summarize();
  end
endmodule

`default_nettype wire
